/* pmw_power_mode_wake_control.sv */
`default_nettype none
module pmw_power_mode_wake_control
	import pmw_pkg::*;
#(
	parameter int OSC_STABLE_CYC  = PMW_OSC_STABLE_CYC,
	parameter int WAKE_SETTLE_CYC = PMW_WAKE_SETTLE_CYC
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_ce,
	input  wire logic                   i_sys_clk_ctrl_wr,
	input  wire logic [2:0]             i_sys_clk_sel,
	input  wire logic                   i_fast_src_sel,
	input  wire logic                   i_low_clk_src_sel,
	input  wire logic                   i_hs_osc_keep_on_halt,
	input  wire logic                   i_ls_osc_keep_on_halt,
	input  wire logic                   i_hs_rc_enable,
	input  wire logic [1:0]             i_hs_rc_freq_sel,
	input  wire logic                   i_hs_crystal_enable,
	input  wire logic                   i_low_speed_crystal_stable,
	input  wire logic                   i_low_speed_rc_stable,
	input  wire logic                   i_halt,
	input  wire logic                   i_clr_wdt,
	input  wire logic                   i_wdt_enable,
	input  wire logic                   i_wdt_overflow,
	input  wire logic                   i_ext_reset_pin_n,
	input  wire logic [PMW_PORTA_W-1:0] i_porta,
	input  wire logic [PMW_PORTA_W-1:0] i_porta_wake_enable,
	input  wire logic [PMW_IRQ_W-1:0]   i_irq_req,
	input  wire logic [PMW_IRQ_W-1:0]   i_irq_enable,
	input  wire logic                   i_stack_full,
	output pmw_mode_t                   o_mode,
	output pmw_clk_t                    o_clk,
	output pmw_event_t                  o_event,
	output logic                        o_powered_down_flag,
	output logic                        o_watchdog_timeout_flag,
	output logic                        o_hs_rc_stable_flag,
	output logic                        o_hs_crystal_stable_flag
);
	typedef struct packed {
		pmw_mode_t            mode;
		pmw_wake_t            wake;
		logic [2:0]           sel_req;
		pmw_clk_t             clk;
		pmw_event_t           ev;
		logic [PMW_IRQ_W-1:0] irq_armed;
		logic [PMW_CNT_W-1:0] settle;
		logic                 powered_down_flag;
		logic                 to;
		logic [1:0]           rc_freq;
		logic                 rc_en;
	} pmw_state_t;

	localparam pmw_state_t PMW_STATE_RESET = '{
		mode:      PMW_RUN,
		wake:      PMW_WK_NONE,
		sel_req:   PMW_SEL_RESET,
		clk:       '{sys_clk_sel: PMW_SEL_RESET, fast_clk_on: 1'b1,
			sub_clk_on: 1'b1, cpu_run: 1'b1, wdt_count_en: 1'b0},
		ev:        '0,
		irq_armed: '0,
		settle:    '0,
		powered_down_flag:       1'b0,
		to:        1'b0,
		rc_freq:   2'h0,
		rc_en:     1'b0
	};

	pmw_state_t           st_reg;
	pmw_state_t           st_next;
	logic                 hs_rc_stable;
	logic                 hs_xtal_stable;
	logic                 hs_stable;
	logic                 ls_stable;
	logic                 porta_fall;
	logic                 rc_restart;
	logic                 low_power;
	logic [PMW_IRQ_W-1:0] irq_wake;

	// Oscillators power down with the fast clock, so their flags re-arm.
	assign rc_restart = (i_hs_rc_enable & ~st_reg.rc_en)
		| (i_hs_rc_freq_sel != st_reg.rc_freq); // R21

	pmw_osc_stable #(
		.STABLE_CYC (OSC_STABLE_CYC)
	) u_hs_rc (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_run     (i_hs_rc_enable & st_reg.clk.fast_clk_on),
		.i_restart (rc_restart),
		.o_stable  (hs_rc_stable)
	);

	pmw_osc_stable #(
		.STABLE_CYC (OSC_STABLE_CYC)
	) u_hs_xtal (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_run     (i_hs_crystal_enable & st_reg.clk.fast_clk_on),
		.i_restart (1'b0),
		.o_stable  (hs_xtal_stable)
	);

	pmw_porta_wake #(
		.WIDTH (PMW_PORTA_W)
	) u_porta (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_ce     (i_ce),
		.i_pin    (i_porta),
		.i_enable (i_porta_wake_enable),
		.o_fall   (porta_fall)
	);

	assign hs_stable = i_fast_src_sel ? hs_xtal_stable : hs_rc_stable;
	assign ls_stable = i_low_clk_src_sel ? i_low_speed_crystal_stable
		: i_low_speed_rc_stable; // R02
	assign low_power = (st_reg.mode == PMW_SLEEP)
		|| (st_reg.mode == PMW_DOZE_SUB_ONLY)
		|| (st_reg.mode == PMW_DOZE_BOTH_CLOCKS)
		|| (st_reg.mode == PMW_DOZE_FAST_ONLY);
	// Requests only count as wake sources while the core is halted, and
	// only on lines that were quiet at the halt instruction. A request
	// that was already pending is left to the core's interrupt logic.
	assign irq_wake = i_irq_req & st_reg.irq_armed
		& {PMW_IRQ_W{low_power}}; // R19

	always_comb begin
		st_next         = st_reg;
		st_next.ev      = '0;
		st_next.rc_en   = i_hs_rc_enable;
		st_next.rc_freq = i_hs_rc_freq_sel;

		// The select and stable trackers follow their inputs every cycle,
		// so a change made while halted is seen at once on return.

		// Halt is applied first so a same-cycle timeout still wins; a same-cycle clear is ignored.
		// The timeout flag is a set-wins flag: an overflow in the halt cycle
		// must not be lost, or software could not tell why it woke.
		if (i_halt && st_reg.mode == PMW_RUN) begin
			st_next.powered_down_flag = 1'b1; // R10 R14
			st_next.to  = 1'b0; // R10
		end
		if (i_clr_wdt && !(i_halt && st_reg.mode == PMW_RUN))
			st_next.powered_down_flag = 1'b0; // R14
		if (i_wdt_overflow)
			st_next.to = 1'b1; // R15

		case (st_reg.mode)
		PMW_RUN: begin
			// Writes are only taken while running; a later write replaces
			// a pending one that has not yet completed.
			if (i_sys_clk_ctrl_wr)
				st_next.sel_req = i_sys_clk_sel;
			// A switch completes only once the target source is stable.
			if (st_reg.sel_req != st_reg.clk.sys_clk_sel) begin
				if (st_reg.sel_req == PMW_SEL_SUB) begin
					if (ls_stable)
						st_next.clk.sys_clk_sel = PMW_SEL_SUB; // R01 R02
				end else if (hs_stable) begin
					st_next.clk.sys_clk_sel = st_reg.sel_req; // R03 R04
				end
			end
			if (i_halt) begin
				st_next.ev.wdt_clear = 1'b1; // R11
				st_next.irq_armed    = ~i_irq_req; // R19
				case ({i_hs_osc_keep_on_halt, i_ls_osc_keep_on_halt}) // R22
				2'b00:   st_next.mode = PMW_SLEEP; // R05
				2'b01:   st_next.mode = PMW_DOZE_SUB_ONLY; // R06
				2'b11:   st_next.mode = PMW_DOZE_BOTH_CLOCKS; // R07
				2'b10:   st_next.mode = PMW_DOZE_FAST_ONLY; // R08
				default: st_next.mode = PMW_SLEEP;
				endcase
			end
		end
		PMW_SLEEP, PMW_DOZE_SUB_ONLY, PMW_DOZE_BOTH_CLOCKS,
		PMW_DOZE_FAST_ONLY: begin
			// Nothing else changes here, so all held state stays as it was.
			// The wake sources are taken in a fixed priority: the reset pin
			// first, then the watchdog, then Port A, then interrupts. Only
			// one wake reason is kept, so a lower source that fires in the
			// same cycle is not recorded by this block.
			st_next.settle = '0; // R09
			if (!i_ext_reset_pin_n) begin
				st_next.wake = PMW_WK_FULL_RESET; // R12 R13
				st_next.mode = PMW_WAKE_WAIT;
			end else if (i_wdt_overflow) begin
				st_next.wake = PMW_WK_WDT_RESET; // R12 R13 R15
				st_next.mode = PMW_WAKE_WAIT;
			end else if (porta_fall) begin
				st_next.wake = PMW_WK_RESUME; // R12 R16
				st_next.mode = PMW_WAKE_WAIT;
			end else if (|irq_wake) begin
				if (|(irq_wake & i_irq_enable) && !i_stack_full)
					st_next.wake = PMW_WK_IRQ; // R18
				else
					st_next.wake = PMW_WK_RESUME; // R17
				st_next.mode = PMW_WAKE_WAIT; // R12
			end
		end
		PMW_WAKE_WAIT: begin
			// Waking waits for the original oscillator, then WAKE_SETTLE_CYC stable cycles.
			// The settle count restarts whenever the source drops out, so a
			// glitching oscillator can never be trusted half way.
			if ((st_reg.clk.sys_clk_sel == PMW_SEL_SUB) ? ls_stable
				: hs_stable) begin
				if (st_reg.settle == PMW_CNT_W'(WAKE_SETTLE_CYC - 1)) begin
					st_next.mode   = PMW_RUN; // R20
					st_next.settle = '0;
					st_next.wake   = PMW_WK_NONE;
					case (st_reg.wake)
					PMW_WK_FULL_RESET: st_next.ev.full_reset = 1'b1; // R13
					PMW_WK_WDT_RESET:  st_next.ev.wdt_reset = 1'b1; // R15
					PMW_WK_IRQ:        st_next.ev.irq_service = 1'b1; // R18
					PMW_WK_RESUME:
						st_next.ev.resume_after_halt = 1'b1; // R16 R17
					default:           st_next.ev.resume_after_halt = 1'b1;
					endcase
				end else begin
					st_next.settle = st_reg.settle + PMW_CNT_W'(1);
				end
			end else begin
				st_next.settle = '0; // R20
			end
		end
		default: st_next.mode = PMW_RUN;
		endcase

		// Clock tree follows the next mode so the outputs stay registered.
		// Driving it from the next state costs a little logic depth but
		// keeps the clock gates in step with the mode the core sees.
		case (st_next.mode)
		PMW_RUN: begin
			// The fast clock stops in slow mode until a return is requested.
			st_next.clk.fast_clk_on =
				(st_next.clk.sys_clk_sel != PMW_SEL_SUB)
				|| (st_next.sel_req != PMW_SEL_SUB); // R04
			st_next.clk.sub_clk_on = 1'b1;
			st_next.clk.cpu_run    = 1'b1;
		end
		PMW_SLEEP: begin
			st_next.clk.fast_clk_on = 1'b0; // R05
			st_next.clk.sub_clk_on  = 1'b0; // R05
			st_next.clk.cpu_run     = 1'b0; // R05
		end
		PMW_DOZE_SUB_ONLY: begin
			st_next.clk.fast_clk_on = 1'b0; // R06
			st_next.clk.sub_clk_on  = 1'b1; // R06
			st_next.clk.cpu_run     = 1'b0; // R06
		end
		PMW_DOZE_BOTH_CLOCKS: begin
			st_next.clk.fast_clk_on = 1'b1; // R07
			st_next.clk.sub_clk_on  = 1'b1; // R07
			st_next.clk.cpu_run     = 1'b0; // R07
		end
		PMW_DOZE_FAST_ONLY: begin
			st_next.clk.fast_clk_on = 1'b1; // R08
			st_next.clk.sub_clk_on  = 1'b0; // R08
			st_next.clk.cpu_run     = 1'b0; // R08
		end
		PMW_WAKE_WAIT: begin
			st_next.clk.fast_clk_on =
				(st_next.clk.sys_clk_sel != PMW_SEL_SUB); // R20
			st_next.clk.sub_clk_on  = 1'b1;
			st_next.clk.cpu_run     = 1'b0; // R20
		end
		default: begin
			st_next.clk.fast_clk_on = 1'b1;
			st_next.clk.sub_clk_on  = 1'b1;
			st_next.clk.cpu_run     = 1'b1;
		end
		endcase
		// The watchdog alone keeps running through sleep when enabled.
		// Its counter lives outside this block; only the enable is passed.
		st_next.clk.wdt_count_en = i_wdt_enable; // R05 R11
	end

	// Reset acts as power-up: the powered-down flag starts clear and the
	// core runs from the undivided fast clock.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			st_reg <= PMW_STATE_RESET; // R14
		else if (i_ce)
			st_reg <= st_next;
	end

	assign o_mode                   = st_reg.mode;
	assign o_clk                    = st_reg.clk;
	assign o_event                  = st_reg.ev;
	assign o_powered_down_flag      = st_reg.powered_down_flag;
	assign o_watchdog_timeout_flag  = st_reg.to;
	assign o_hs_rc_stable_flag      = hs_rc_stable;
	assign o_hs_crystal_stable_flag = hs_xtal_stable;
endmodule
`default_nettype wire

/* pmw_pkg.sv */
// Behaviour
// R01: Writing 111 to the clock select while fast moves the system clock to sub-clock.
// R02: Slow clock comes from the low-speed crystal or RC, switching once that source is stable.
// R03: Select values 000 to 110 pick the fast clock divided by 1 up to 64.
// R04: A stopped fast clock restarts on return; its stable flag shows when usable.
// R05: Halt with both keep-on bits low sleeps; only the watchdog keeps working.
// R06: Halt with fast keep-on low, slow keep-on high stops fast clock, keeps sub-clock.
// R07: Halt with both keep-on bits high keeps both clocks, stops program execution.
// R08: Halt with fast keep-on high, slow keep-on low keeps fast clock, stops sub-clock.
// R09: Every low-power state holds memory, registers and port states unchanged.
// R10: Every halt sets the powered-down flag and clears the watchdog-timeout flag; an overflow in the halt cycle leaves the timeout flag set here.
// R11: Every halt clears the watchdog counter; it counts on only if enabled.
// R12: Wake on reset pin, enabled Port A falling edge, interrupt or watchdog overflow.
// R13: Reset pin wake gives a full reset; watchdog wake gives a watchdog reset.
// R14: Powered-down flag clears on power-up or clear-watchdog, sets on halt.
// R15: Watchdog wake sets the timeout flag and resets only program counter and stack.
// R16: Each Port A pin is enabled individually; a falling edge resumes after halt.
// R17: Disabled interrupt or full stack resumes after halt, interrupt stays pending.
// R18: Enabled interrupt with a free stack level gets its normal response on wake.
// R19: An interrupt already requested before halt cannot wake that low-power period.
// R20: Execution resumes only after the original system oscillator has restabilised.
// R21: Enabling or retuning the fast RC clears its stable flag, then sets it when stable.
// R22: Both keep-on bits are sampled in the halt cycle to choose the low-power state.
`default_nettype none
package pmw_pkg;

	localparam int PMW_PORTA_W = 8;
	localparam int PMW_IRQ_W   = 8;

	localparam logic [2:0] PMW_SEL_SUB   = 3'h7;
	localparam logic [2:0] PMW_SEL_RESET = 3'h0;

	// Clock rate and oscillator settling figures.
	localparam int PMW_CLK_PERIOD_NS  = 25;
	localparam int PMW_OSC_STABLE_NS  = 16000;
	localparam int PMW_OSC_STABLE_CYC =
		(PMW_OSC_STABLE_NS + PMW_CLK_PERIOD_NS - 1) / PMW_CLK_PERIOD_NS;
	localparam int PMW_WAKE_SETTLE_NS  = 1000;
	localparam int PMW_WAKE_SETTLE_CYC =
		(PMW_WAKE_SETTLE_NS + PMW_CLK_PERIOD_NS - 1) / PMW_CLK_PERIOD_NS;
	localparam int PMW_CNT_W = 16;

	typedef enum logic [2:0] {
		PMW_RUN,
		PMW_SLEEP,
		PMW_DOZE_SUB_ONLY,
		PMW_DOZE_BOTH_CLOCKS,
		PMW_DOZE_FAST_ONLY,
		PMW_WAKE_WAIT
	} pmw_mode_t;

	typedef enum logic [2:0] {
		PMW_WK_NONE,
		PMW_WK_FULL_RESET,
		PMW_WK_WDT_RESET,
		PMW_WK_RESUME,
		PMW_WK_IRQ
	} pmw_wake_t;

	// Pulses reported to the CPU core when a wake completes; wdt_clear pulses at halt.
	typedef struct packed {
		logic full_reset;
		logic wdt_reset;
		logic resume_after_halt;
		logic irq_service;
		logic wdt_clear;
	} pmw_event_t;

	// Clock and power state presented to the clock tree.
	typedef struct packed {
		logic [2:0] sys_clk_sel;
		logic       fast_clk_on;
		logic       sub_clk_on;
		logic       cpu_run;
		logic       wdt_count_en;
	} pmw_clk_t;

endpackage
`default_nettype wire

/* pmw_osc_stable.sv */
`default_nettype none
module pmw_osc_stable
	import pmw_pkg::*;
#(
	parameter int STABLE_CYC = PMW_OSC_STABLE_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	input  wire logic i_run,
	input  wire logic i_restart,
	output logic      o_stable
);
	typedef struct packed {
		logic [PMW_CNT_W-1:0] cnt;
		logic                 stable;
	} pmw_osc_st_t;

	pmw_osc_st_t st_reg;
	pmw_osc_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (!i_run || i_restart) begin
			st_next.cnt    = '0; // R21
			st_next.stable = 1'b0; // R21
		end else if (!st_reg.stable) begin
			if (st_reg.cnt == PMW_CNT_W'(STABLE_CYC - 1))
				st_next.stable = 1'b1; // R21
			else
				st_next.cnt = st_reg.cnt + PMW_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			st_reg <= '0;
		else if (i_ce)
			st_reg <= st_next;
	end

	assign o_stable = st_reg.stable;
endmodule
`default_nettype wire

/* pmw_porta_wake.sv */
`default_nettype none
module pmw_porta_wake
	import pmw_pkg::*;
#(
	parameter int WIDTH = PMW_PORTA_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_pin,
	input  wire logic [WIDTH-1:0] i_enable,
	output logic                  o_fall
);
	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic             fall;
	} pmw_pw_st_t;

	pmw_pw_st_t       st_reg;
	pmw_pw_st_t       st_next;
	logic [WIDTH-1:0] edge_hit;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			assign edge_hit[g] = i_enable[g] & st_reg.prev[g] & ~i_pin[g]; // R16
		end
	endgenerate

	always_comb begin
		st_next      = st_reg;
		st_next.prev = i_pin;
		st_next.fall = |edge_hit;
	end

	// Previous level resets high so a pin held low at reset counts as a falling edge.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			st_reg <= '{prev: '1, fall: 1'b0};
		else if (i_ce)
			st_reg <= st_next;
	end

	assign o_fall = st_reg.fall;
endmodule
`default_nettype wire

/* pmw_props_properties.sv */
`default_nettype none
module pmw_props
	import pmw_pkg::*;
#(
	parameter int OSC_STABLE_CYC  = PMW_OSC_STABLE_CYC,
	parameter int WAKE_SETTLE_CYC = PMW_WAKE_SETTLE_CYC
) (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_ce,
	input wire logic       i_sys_clk_ctrl_wr,
	input wire logic [2:0] i_sys_clk_sel,
	input wire logic       i_low_clk_src_sel,
	input wire logic       i_hs_osc_keep_on_halt,
	input wire logic       i_ls_osc_keep_on_halt,
	input wire logic       i_low_speed_crystal_stable,
	input wire logic       i_low_speed_rc_stable,
	input wire logic       i_halt,
	input wire logic       i_wdt_overflow,
	input wire logic       i_ext_reset_pin_n,
	input wire pmw_mode_t  o_mode,
	input wire pmw_clk_t   o_clk,
	input wire pmw_event_t o_event,
	input wire logic       o_powered_down_flag,
	input wire logic       o_watchdog_timeout_flag
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic       lp;
	logic       halt_ok;
	logic       lo_ok;
	logic [1:0] keep;
	pmw_mode_t  exp_mode;

	assign lp = o_mode inside {PMW_SLEEP, PMW_DOZE_SUB_ONLY,
		PMW_DOZE_BOTH_CLOCKS, PMW_DOZE_FAST_ONLY};
	assign halt_ok = i_ce && i_halt && o_mode == PMW_RUN;
	assign lo_ok = i_low_clk_src_sel ? i_low_speed_crystal_stable
		: i_low_speed_rc_stable;
	assign keep = {i_hs_osc_keep_on_halt, i_ls_osc_keep_on_halt};
	always_comb begin
		case (keep)
			2'b00: exp_mode = PMW_SLEEP;
			2'b01: exp_mode = PMW_DOZE_SUB_ONLY;
			2'b11: exp_mode = PMW_DOZE_BOTH_CLOCKS;
			default: exp_mode = PMW_DOZE_FAST_ONLY;
		endcase
	end

	halt_mode_a: assert property (
		halt_ok |=> o_mode == $past(exp_mode) && !o_clk.cpu_run
		&& {o_clk.fast_clk_on, o_clk.sub_clk_on} == $past(keep))
		else $error("halt entered the wrong state");
	halt_flags_a: assert property (
		halt_ok && !i_wdt_overflow |=> o_powered_down_flag
		&& !o_watchdog_timeout_flag) else $error("halt flags wrong");
	halt_wdt_clear_a: assert property (
		halt_ok |=> o_event.wdt_clear) else $error("no watchdog clear");
	sub_switch_a: assert property (
		i_ce && i_sys_clk_ctrl_wr && i_sys_clk_sel == 3'h7 && lo_ok
		&& o_mode == PMW_RUN |-> ##[1:3] o_clk.sys_clk_sel == 3'h7)
		else $error("sub-clock switch late");
	hold_state_a: assert property (
		lp |=> $stable(o_clk.sys_clk_sel)) else $error("select moved");
	ext_wake_a: assert property (
		lp && i_ce && !i_ext_reset_pin_n |=> o_mode == PMW_WAKE_WAIT)
		else $error("reset pin did not wake");
	wdt_wake_a: assert property (
		lp && i_ce && i_ext_reset_pin_n && i_wdt_overflow
		|=> o_mode == PMW_WAKE_WAIT && o_watchdog_timeout_flag)
		else $error("watchdog wake wrong");
	wake_bound_a: assert property (
		o_mode == PMW_WAKE_WAIT |-> ##[1:1000] o_mode == PMW_RUN)
		else $error("wake never completed");
endmodule
`default_nettype wire

/* pmw_osc_model.sv */
`default_nettype none
module pmw_osc_model #(
	parameter int SLOW_CYC = 30
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_kick,
	output logic      o_crystal_stable,
	output logic      o_rc_stable
);
	int cnt_reg = 0;

	// The crystal is slow to start, so a kick makes it unstable for a while.
	always @(posedge i_clk) begin
		if (!i_rst_n || i_kick) begin
			cnt_reg <= SLOW_CYC;
		end else if (cnt_reg != 0) begin
			cnt_reg <= cnt_reg - 1;
		end
	end
	assign o_crystal_stable = (cnt_reg == 0);
	assign o_rc_stable = i_rst_n;
endmodule
`default_nettype wire

/* tb_power_mode_wake_control.sv */
`default_nettype none
module tb_power_mode_wake_control
	import pmw_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic       i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, kick = 1'b0;
	logic       i_sys_clk_ctrl_wr = 1'b0, i_fast_src_sel = 1'b0;
	logic       i_low_clk_src_sel = 1'b0, i_hs_crystal_enable = 1'b0;
	logic       i_hs_osc_keep_on_halt = 1'b0, i_ls_osc_keep_on_halt = 1'b0;
	logic       i_hs_rc_enable = 1'b1, i_halt = 1'b0, i_clr_wdt = 1'b0;
	logic       i_wdt_enable = 1'b0, i_wdt_overflow = 1'b0;
	logic       i_ext_reset_pin_n = 1'b1, i_stack_full = 1'b0;
	logic       i_low_speed_crystal_stable, i_low_speed_rc_stable;
	logic [2:0] i_sys_clk_sel = 3'h0;
	logic [1:0] i_hs_rc_freq_sel = 2'h0;
	logic [7:0] i_porta = 8'hff, i_porta_wake_enable = 8'h08;
	logic [7:0] i_irq_req = 8'h00, i_irq_enable = 8'hff;
	pmw_mode_t  o_mode;
	pmw_clk_t   o_clk;
	pmw_event_t o_event;
	logic       o_powered_down_flag, o_watchdog_timeout_flag;
	logic       o_hs_rc_stable_flag, o_hs_crystal_stable_flag;
	int         n_fail = 0, n_checks = 0, cyc = 0;

	always #12.5 i_clk = ~i_clk;

	pmw_power_mode_wake_control #(
		.OSC_STABLE_CYC (4),
		.WAKE_SETTLE_CYC(2)
	) u_dut (
		.i_clk, .i_rst_n, .i_ce, .i_sys_clk_ctrl_wr, .i_sys_clk_sel,
		.i_fast_src_sel, .i_low_clk_src_sel, .i_hs_osc_keep_on_halt,
		.i_ls_osc_keep_on_halt, .i_hs_rc_enable, .i_hs_rc_freq_sel,
		.i_hs_crystal_enable, .i_low_speed_crystal_stable,
		.i_low_speed_rc_stable, .i_halt, .i_clr_wdt, .i_wdt_enable,
		.i_wdt_overflow, .i_ext_reset_pin_n, .i_porta, .i_porta_wake_enable,
		.i_irq_req, .i_irq_enable, .i_stack_full, .o_mode, .o_clk, .o_event,
		.o_powered_down_flag, .o_watchdog_timeout_flag,
		.o_hs_rc_stable_flag, .o_hs_crystal_stable_flag
	);

	pmw_osc_model u_osc (
		.i_clk, .i_rst_n, .i_kick(kick),
		.o_crystal_stable(i_low_speed_crystal_stable),
		.o_rc_stable(i_low_speed_rc_stable)
	);

	task automatic summarize();
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wsel(input logic [2:0] s);
		@(posedge i_clk);
		i_sys_clk_ctrl_wr <= 1'b1;
		i_sys_clk_sel <= s;
		@(posedge i_clk);
		i_sys_clk_ctrl_wr <= 1'b0;
	endtask

	task automatic wait_sel(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (o_clk.sys_clk_sel !== s && n < 100);
		check(8'(o_clk.sys_clk_sel), 8'(s));
	endtask

	// Software must not lean on the fast clock until its flag is up.
	task automatic wait_rc();
		int n;
		n = 0;
		while (o_hs_rc_stable_flag !== 1'b1 && n < 50) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		check(8'(o_hs_rc_stable_flag), 8'h1);
	endtask

	task automatic wait_run(output pmw_event_t e);
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (o_mode !== PMW_RUN && n < 1000);
		e = o_event;
		check(8'(o_mode), 8'(PMW_RUN));
	endtask

	task automatic do_halt(input logic h, input logic l);
		pmw_mode_t em;
		em = h ? (l ? PMW_DOZE_BOTH_CLOCKS : PMW_DOZE_FAST_ONLY)
			: (l ? PMW_DOZE_SUB_ONLY : PMW_SLEEP);
		@(posedge i_clk);
		i_hs_osc_keep_on_halt <= h;
		i_ls_osc_keep_on_halt <= l;
		i_halt <= 1'b1;
		@(posedge i_clk);
		i_halt <= 1'b0;
		#1;
		check(8'(o_mode), 8'(em));
		check(8'({o_clk.fast_clk_on, o_clk.sub_clk_on}), 8'({h, l}));
		check({6'h0, o_powered_down_flag, o_watchdog_timeout_flag}, 8'h2);
	endtask

	task automatic t_reset();
		@(posedge i_clk);
		#1;
		check(8'(o_mode), 8'(PMW_RUN));
		check(8'({o_clk.sys_clk_sel, o_powered_down_flag}), 8'h0);
		wait_rc();
	endtask

	task automatic t_clk();
		for (int v = 0; v < 7; v++) begin
			wsel(3'h7);
			wait_sel(3'h7);
			wsel(3'(v));
			wait_sel(3'(v));
		end
		@(posedge i_clk);
		kick <= 1'b1;
		i_low_clk_src_sel <= 1'b1;
		@(posedge i_clk);
		kick <= 1'b0;
		wsel(3'h7);
		repeat (5) @(posedge i_clk);
		#1;
		check(8'(o_clk.sys_clk_sel), 8'h6);
		wait_sel(3'h7);
		wsel(3'h0);
		wait_sel(3'h0);
	endtask

	task automatic t_rc();
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			if (k == 0) i_hs_rc_freq_sel <= 2'h1;
			else i_hs_rc_enable <= 1'b0;
			@(posedge i_clk);
			i_hs_rc_enable <= 1'b1;
			@(posedge i_clk);
			#1;
			check(8'(o_hs_rc_stable_flag), 8'h0);
			wait_rc();
		end
		@(posedge i_clk);
		i_hs_crystal_enable <= 1'b1;
		@(posedge i_clk);
		#1;
		check(8'(o_hs_crystal_stable_flag), 8'h0);
		repeat (6) @(posedge i_clk);
		#1;
		check(8'(o_hs_crystal_stable_flag), 8'h1);
		@(posedge i_clk);
		i_ce <= 1'b0;
		i_halt <= 1'b1;
		@(posedge i_clk);
		i_ce <= 1'b1;
		i_halt <= 1'b0;
		#1;
		check(8'(o_mode), 8'(PMW_RUN));
	endtask

	task automatic t_halt();
		pmw_event_t e;
		for (int k = 0; k < 4; k++) begin
			do_halt(k[1], k[0]);
			@(posedge i_clk);
			i_porta <= 8'hfe;
			repeat (4) @(posedge i_clk);
			#1;
			check(8'(o_clk.cpu_run), 8'h0);
			@(posedge i_clk);
			i_porta <= 8'hf6;
			wait_run(e);
			check(8'(e.resume_after_halt), 8'h1);
			@(posedge i_clk);
			i_porta <= 8'hff;
		end
	endtask

	task automatic t_wdt();
		pmw_event_t e;
		@(posedge i_clk);
		i_wdt_enable <= 1'b1;
		do_halt(1'b0, 1'b1);
		@(posedge i_clk);
		i_wdt_overflow <= 1'b1;
		@(posedge i_clk);
		i_wdt_overflow <= 1'b0;
		wait_run(e);
		check(8'(e.wdt_reset), 8'h1);
		check({6'h0, o_watchdog_timeout_flag, o_powered_down_flag}, 8'h3);
		check(8'(o_clk.wdt_count_en), 8'h1);
		@(posedge i_clk);
		i_clr_wdt <= 1'b1;
		@(posedge i_clk);
		i_clr_wdt <= 1'b0;
		@(posedge i_clk);
		#1;
		check(8'(o_powered_down_flag), 8'h0);
	endtask

	task automatic t_ext();
		pmw_event_t e;
		do_halt(1'b1, 1'b0);
		@(posedge i_clk);
		i_ext_reset_pin_n <= 1'b0;
		@(posedge i_clk);
		i_ext_reset_pin_n <= 1'b1;
		wait_run(e);
		check(8'(e.full_reset), 8'h1);
	endtask

	// A request already pending at halt must not wake; new ones must.
	task automatic t_irq();
		pmw_event_t e;
		logic [7:0] ex;
		@(posedge i_clk);
		i_irq_req <= 8'h01;
		for (int k = 0; k < 3; k++) begin
			ex = (k == 0) ? 8'h2 : 8'h1;
			do_halt(1'b1, 1'b1);
			repeat (4) @(posedge i_clk);
			#1;
			check(8'(o_mode), 8'(PMW_DOZE_BOTH_CLOCKS));
			@(posedge i_clk);
			i_irq_req <= 8'h01 | (8'h02 << k);
			i_irq_enable <= (k == 1) ? 8'h00 : 8'hff;
			i_stack_full <= (k == 2);
			wait_run(e);
			check({6'h0, e.irq_service, e.resume_after_halt}, ex);
			@(posedge i_clk);
			i_irq_req <= 8'h01;
			i_irq_enable <= 8'hff;
			i_stack_full <= 1'b0;
		end
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_clk();
		t_rc();
		t_halt();
		t_wdt();
		t_ext();
		t_irq();
		summarize();
	end
endmodule

bind pmw_power_mode_wake_control pmw_props #(
	.OSC_STABLE_CYC (OSC_STABLE_CYC),
	.WAKE_SETTLE_CYC(WAKE_SETTLE_CYC)
) u_props (
	.i_clk, .i_rst_n, .i_ce, .i_sys_clk_ctrl_wr, .i_sys_clk_sel,
	.i_low_clk_src_sel, .i_hs_osc_keep_on_halt, .i_ls_osc_keep_on_halt,
	.i_low_speed_crystal_stable, .i_low_speed_rc_stable, .i_halt,
	.i_wdt_overflow, .i_ext_reset_pin_n, .o_mode, .o_clk, .o_event,
	.o_powered_down_flag, .o_watchdog_timeout_flag
);
`default_nettype wire
